// ### rtl/scs_clock_select.sv
// What this block does
// (R1) Middle-speed RC offers 64, 128, 256 and 512 kHz via the frequency field.
// (R2) Fast clock comes from fast crystal, fast RC or middle RC by source bits.
// (R3) Subclock comes from slow crystal or internal slow RC by the low source bit.
// (R4) System clock picks fast clock family or subclock by the select field.
// (R5) System clock may also be the fast clock divided by 2 up to 64.
// (R6) Writing crystal enable to 1 starts it; output invalid until start-up passes.
// (R7) Crystal mode bit: 0 is low power, 1 is speed-up.
// (R8) Software starts crystal in speed-up and may later drop to low power.
// (R9) While the slow crystal drives the system clock, mode writes are ignored.
// (R10) Both crystal modes run correctly; low power only needs a longer start.
// (R11) Pin-share bit connects crystal pins to the oscillator or to general use.
// (R12) On move to subclock the fast oscillator stops or runs per its enable.
// (R13) Software sets the RC frequency field to match the configured frequency.
// (R14) In sleep or idle the system clock stops; timer clocks may continue.
// (R15) Select field is bits 7 to 5; 0 to 6 fast family, 7 subclock.
// (R16) Crystal enabled, ready and source bit 1 picks crystal and stops slow RC.
// (R17) Ready flag rises after a mode-dependent start-up count from enable.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module scs_clock_select #(
	parameter logic [scs_pkg::SU_W-1:0] SU_FAST_CYC = scs_pkg::SU_W'(scs_pkg::LXT_SU_FAST_CYC),
	parameter logic [scs_pkg::SU_W-1:0] SU_SLOW_CYC = scs_pkg::SU_W'(scs_pkg::LXT_SU_SLOW_CYC)
) (
	// Clock and reset.
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	// Register port.
	input  wire logic [1:0]           addr,
	input  wire logic [7:0]           wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic      [7:0]           rdata,
	// CPU halt state for sleep and idle.
	input  wire logic                 halt,
	// Oscillator outputs and enables.
	input  wire scs_pkg::scs_osc_s    osc,
	output scs_pkg::scs_osc_en_s      osc_en,
	output logic      [2:0]           rc_freq_code,
	output logic                      xt_pin_osc,
	// Clocks produced.
	output logic                      sys_clk,
	output logic                      hs_clk,
	output logic                      sub_clk
);

	////////////////////////////////////////////////////////////////////////////
	// Decode of the internal RC field, used by the source mux and the enables.
	function automatic logic is_middle_speed_rc_osc(input logic [2:0] code);
		is_middle_speed_rc_osc = (code < scs_pkg::IRC_FIRST_HIGH_SPEED_RC_OSC); // [R1]
	endfunction : is_middle_speed_rc_osc

	logic [2:0]              cks_q, cks_d, irc_q, irc_d;
	logic                    fhs_q, fhs_d, fss_q, fss_d, fhiden_q, fhiden_d, fsiden_q, fsiden_d;
	logic                    ircen_q, ircen_d, ircf_q, ircf_d, hxten_q, hxten_d;
	logic                    slow_crystal_speedup_q, slow_crystal_speedup_d, slow_crystal_enable_q, slow_crystal_enable_d, slow_crystal_ready_q, slow_crystal_ready_d, pinsel_q, pinsel_d;
	logic [scs_pkg::SU_W-1:0] su_cnt_q, su_cnt_d, su_limit;
	logic [scs_pkg::DIV_W-1:0] div_q, div_d;
	logic                    hs_prev_q, hs_prev_d, sys_q, sys_d, hs_q, hs_d, sub_q, sub_d;
	logic [7:0]              rdata_q, rdata_d;
	scs_pkg::scs_osc_s       osc_lvl;
	logic                    hs_lvl, sub_lvl, sub_from_lxt, fast_mode, sp_locked, hs_edge, div_lvl;

	////////////////////////////////////////////////////////////////////////////
	// Oscillator outputs come from other clocks and are filtered first.
	scs_sync3 #(
		.W($bits(scs_pkg::scs_osc_s))
	) u_sync (
		.clk_sys(clk_sys),
		.rst    (rst),
		.d      (osc),
		.q      (osc_lvl)
	);

	////////////////////////////////////////////////////////////////////////////
	// Source selection and derived conditions.
	always_comb begin
		sub_from_lxt = slow_crystal_enable_q & slow_crystal_ready_q & fss_q; // [R16]
		sub_lvl      = sub_from_lxt ? osc_lvl.slow_crystal_osc : osc_lvl.low_speed_rc_osc; // [R3]
		if (fhs_q) begin
			hs_lvl = osc_lvl.fast_crystal_osc; // [R2]
		end else if (is_middle_speed_rc_osc(irc_q)) begin
			hs_lvl = osc_lvl.middle_speed_rc_osc;
		end else begin
			hs_lvl = osc_lvl.high_speed_rc_osc;
		end
		fast_mode = (cks_q != scs_pkg::CKS_SUB); // [R15]
		// The crystal may not change mode while it is clocking the CPU.
		sp_locked = !fast_mode & sub_from_lxt; // [R9]
		hs_edge   = hs_lvl & !hs_prev_q;
		// Bit 5 toggles every 32 fast edges, bit 0 on every one.
		div_lvl   = div_q[3'(3'h5 - cks_q)]; // [R5]
		su_limit  = slow_crystal_speedup_q ? SU_FAST_CYC : SU_SLOW_CYC; // [R10] [R17]
	end

	////////////////////////////////////////////////////////////////////////////
	// Oscillator enables follow the control bits directly.
	always_comb begin
		osc_en.slow_crystal_osc         = slow_crystal_enable_q; // [R6]
		osc_en.lxt_speedup = slow_crystal_speedup_q; // [R7]
		osc_en.low_speed_rc_osc        = !sub_from_lxt; // [R16]
		// In slow mode a fast source only runs if its own enable keeps it.
		osc_en.fast_crystal_osc         = fhs_q & (fast_mode | hxten_q); // [R12]
		osc_en.middle_speed_rc_osc        = !fhs_q & is_middle_speed_rc_osc(irc_q) & (fast_mode | ircen_q); // [R12]
		osc_en.high_speed_rc_osc        = !fhs_q & !is_middle_speed_rc_osc(irc_q) & (fast_mode | ircen_q);
	end

	assign rc_freq_code = irc_q; // [R1]
	assign xt_pin_osc   = pinsel_q; // [R11]
	assign sys_clk      = sys_q;
	assign hs_clk       = hs_q;
	assign sub_clk      = sub_q;
	assign rdata        = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Next state of registers, counters and clock outputs.
	always_comb begin
		cks_d     = cks_q;
		irc_d     = irc_q;
		fhs_d     = fhs_q;
		fss_d     = fss_q;
		fhiden_d  = fhiden_q;
		fsiden_d  = fsiden_q;
		ircen_d   = ircen_q;
		hxten_d   = hxten_q;
		slow_crystal_speedup_d   = slow_crystal_speedup_q;
		slow_crystal_enable_d   = slow_crystal_enable_q;
		pinsel_d  = pinsel_q;
		rdata_d   = 8'h00;
		if (wr) begin
			case (addr)
				scs_pkg::ADDR_SCC: begin
					cks_d    = wdata[scs_pkg::SCC_CKS_LSB +: 3]; // [R4] [R15]
					fhs_d    = wdata[scs_pkg::SCC_FHS];
					fss_d    = wdata[scs_pkg::SCC_FSS];
					fhiden_d = wdata[scs_pkg::SCC_FHIDEN];
					fsiden_d = wdata[scs_pkg::SCC_FSIDEN];
				end
				scs_pkg::ADDR_INTERNAL_RC_CONTROL: begin
					irc_d   = wdata[scs_pkg::INTERNAL_RC_CONTROL_IRC_LSB +: 3];
					ircen_d = wdata[scs_pkg::INTERNAL_RC_CONTROL_EN];
				end
				scs_pkg::ADDR_HXTC: begin
					hxten_d = wdata[scs_pkg::HXTC_EN];
				end
				scs_pkg::ADDR_LXTC: begin
					if (!sp_locked) begin
						slow_crystal_speedup_d = wdata[scs_pkg::LXTC_SP]; // [R9]
					end
					slow_crystal_enable_d  = wdata[scs_pkg::LXTC_EN]; // [R6]
					pinsel_d = wdata[scs_pkg::LXTC_PINSEL]; // [R11]
				end
				default: begin
				end
			endcase
		end
		if (rd) begin
			case (addr)
				scs_pkg::ADDR_SCC:  rdata_d = {cks_q, 1'b0, fhs_q, fss_q, fhiden_q, fsiden_q};
				scs_pkg::ADDR_INTERNAL_RC_CONTROL: rdata_d = {3'h0, irc_q, ircf_q, ircen_q};
				scs_pkg::ADDR_HXTC: rdata_d = {7'h00, hxten_q};
				scs_pkg::ADDR_LXTC: rdata_d = {4'h0, pinsel_q, slow_crystal_speedup_q, slow_crystal_ready_q, slow_crystal_enable_q};
				default:            rdata_d = 8'h00;
			endcase
		end
		// Start-up count; ready clears one cycle after the crystal is disabled.
		if (!slow_crystal_enable_q) begin
			su_cnt_d = '0;
			slow_crystal_ready_d   = 1'b0; // [R6]
		end else if (!slow_crystal_ready_q && su_cnt_q >= su_limit - 1'b1) begin
			su_cnt_d = su_cnt_q;
			slow_crystal_ready_d   = 1'b1; // [R17]
		end else begin
			su_cnt_d = slow_crystal_ready_q ? su_cnt_q : su_cnt_q + 1'b1;
			slow_crystal_ready_d   = slow_crystal_ready_q;
		end
		// Internal RC is taken as ready after its first edge while running.
		if (fhs_q || !(osc_en.middle_speed_rc_osc | osc_en.high_speed_rc_osc)) begin
			ircf_d = 1'b0;
		end else begin
			ircf_d = ircf_q | hs_edge;
		end
		hs_prev_d = hs_lvl;
		div_d     = hs_edge ? div_q + 1'b1 : div_q; // [R5]
		// The system clock stops while halted; peripheral clocks obey the idle enables.
		if (halt) begin
			sys_d = 1'b0; // [R14]
		end else if (cks_q == scs_pkg::CKS_SUB) begin
			sys_d = sub_lvl; // [R4]
		end else if (cks_q == scs_pkg::CKS_UNDIV) begin
			sys_d = hs_lvl;
		end else begin
			sys_d = div_lvl;
		end
		hs_d  = hs_lvl & (!halt | fhiden_q); // [R14]
		sub_d = sub_lvl & (!halt | fsiden_q); // [R14]
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cks_q     <= scs_pkg::CKS_RST;
			irc_q     <= scs_pkg::IRC_RST;
			fhs_q     <= 1'b0;
			fss_q     <= 1'b0;
			fhiden_q  <= 1'b0;
			fsiden_q  <= 1'b0;
			ircen_q   <= scs_pkg::IRCEN_RST;
			ircf_q    <= 1'b0;
			hxten_q   <= scs_pkg::HXTEN_RST;
			slow_crystal_speedup_q   <= scs_pkg::SLOW_CRYSTAL_SPEEDUP_RST;
			slow_crystal_enable_q   <= 1'b0;
			slow_crystal_ready_q    <= 1'b0;
			pinsel_q  <= 1'b0;
			su_cnt_q  <= '0;
			div_q     <= '0;
			hs_prev_q <= 1'b0;
			sys_q     <= 1'b0;
			hs_q      <= 1'b0;
			sub_q     <= 1'b0;
			rdata_q   <= 8'h00;
		end else begin
			cks_q     <= cks_d;
			irc_q     <= irc_d;
			fhs_q     <= fhs_d;
			fss_q     <= fss_d;
			fhiden_q  <= fhiden_d;
			fsiden_q  <= fsiden_d;
			ircen_q   <= ircen_d;
			ircf_q    <= ircf_d;
			hxten_q   <= hxten_d;
			slow_crystal_speedup_q   <= slow_crystal_speedup_d;
			slow_crystal_enable_q   <= slow_crystal_enable_d;
			slow_crystal_ready_q    <= slow_crystal_ready_d;
			pinsel_q  <= pinsel_d;
			su_cnt_q  <= su_cnt_d;
			div_q     <= div_d;
			hs_prev_q <= hs_prev_d;
			sys_q     <= sys_d;
			hs_q      <= hs_d;
			sub_q     <= sub_d;
			rdata_q   <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_lxtc_write;
		wr && addr == scs_pkg::ADDR_LXTC;
	endsequence

	sequence s_lxt_start;
		s_lxtc_write and (wdata[scs_pkg::LXTC_EN] && !slow_crystal_enable_q);
	endsequence

	AST_LXT_STARTS: assert property (s_lxt_start |=> osc_en.slow_crystal_osc && !slow_crystal_ready_q) // [R6]
		else $error("Crystal did not start or was ready at once.");
	AST_NOT_READY_OFF: assert property (!slow_crystal_enable_q |=> !slow_crystal_ready_q) // [R6]
		else $error("Crystal ready while disabled.");
	AST_READY_AT_COUNT: assert property ($rose(slow_crystal_ready_q) |-> $past(su_cnt_q) >= $past(su_limit) - 1'b1) // [R17]
		else $error("Crystal ready before the start-up count.");
	AST_SP_LOCK: assert property ((s_lxtc_write and sp_locked) |=> $stable(slow_crystal_speedup_q)) // [R9]
		else $error("Crystal mode changed while it clocks the system.");
	AST_SP_MODE: assert property (osc_en.lxt_speedup == slow_crystal_speedup_q && su_limit == (slow_crystal_speedup_q ? SU_FAST_CYC : SU_SLOW_CYC)) // [R7] [R10]
		else $error("Crystal mode or start-up length wrong.");
	AST_SUB_SRC: assert property (sub_from_lxt |-> !osc_en.low_speed_rc_osc ##1 (sub_q == $past(osc_lvl.slow_crystal_osc) || halt || $past(halt))) // [R16] [R3]
		else $error("Subclock not from crystal or slow RC still on.");
	AST_HALT_STOP: assert property (halt [*2] |-> !sys_clk) // [R14]
		else $error("System clock ran while halted.");
	AST_HS_STOP: assert property ((cks_q == scs_pkg::CKS_SUB && fhs_q && !hxten_q) |-> !osc_en.fast_crystal_osc) // [R12]
		else $error("Fast crystal kept running without its enable.");
	AST_MIDDLE_SPEED_RC_OSC_SRC: assert property ((!fhs_q && is_middle_speed_rc_osc(irc_q) && fast_mode) |-> osc_en.middle_speed_rc_osc && !osc_en.high_speed_rc_osc) // [R2] [R1]
		else $error("Middle-speed RC not selected.");
	AST_DIV: assert property ((!halt && cks_q == 3'h5) [*2] |-> sys_clk == $past(div_q[0])) // [R5]
		else $error("Divide-by-two output wrong.");

endmodule : scs_clock_select

// ### rtl/scs_pkg.sv
package scs_pkg;

	// Register word addresses on the plain register port.
	localparam logic [1:0] ADDR_SCC  = 2'h0;
	localparam logic [1:0] ADDR_INTERNAL_RC_CONTROL = 2'h1;
	localparam logic [1:0] ADDR_HXTC = 2'h2;
	localparam logic [1:0] ADDR_LXTC = 2'h3;

	// Field positions.
	localparam int SCC_CKS_LSB  = 5;
	localparam int SCC_FHS      = 3;
	localparam int SCC_FSS      = 2;
	localparam int SCC_FHIDEN   = 1;
	localparam int SCC_FSIDEN   = 0;
	localparam int INTERNAL_RC_CONTROL_IRC_LSB = 2;
	localparam int INTERNAL_RC_CONTROL_RDY     = 1;
	localparam int INTERNAL_RC_CONTROL_EN      = 0;
	localparam int HXTC_EN      = 0;
	localparam int LXTC_PINSEL  = 3;
	localparam int LXTC_SP      = 2;
	localparam int LXTC_RDY     = 1;
	localparam int LXTC_EN      = 0;

	// Values after reset.
	localparam logic [2:0] CKS_RST   = 3'h7;
	localparam logic [2:0] IRC_RST   = 3'h4;
	localparam logic       IRCEN_RST = 1'h1;
	localparam logic       HXTEN_RST = 1'h0;
	localparam logic       SLOW_CRYSTAL_SPEEDUP_RST = 1'h1;

	// System clock select codes: 0..5 divide by 64 down to 2, 6 undivided, 7 subclock.
	localparam logic [2:0] CKS_UNDIV = 3'h6;
	localparam logic [2:0] CKS_SUB   = 3'h7;
	localparam int         DIV_W     = 6;

	// Internal RC frequency codes 0..3 pick the middle-speed RC, 4..7 the fast RC.
	localparam logic [2:0] IRC_FIRST_HIGH_SPEED_RC_OSC = 3'h4;

	// Slow crystal start-up intervals.
	localparam int CLK_MHZ        = 200;
	localparam int LXT_SU_FAST_US = 1000;
	localparam int LXT_SU_SLOW_US = 2000;
	localparam int LXT_SU_FAST_CYC = LXT_SU_FAST_US * CLK_MHZ;
	localparam int LXT_SU_SLOW_CYC = LXT_SU_SLOW_US * CLK_MHZ;
	localparam int SU_W            = 20;

	// Oscillator outputs arriving at the block.
	typedef struct packed {
		logic fast_crystal_osc;
		logic high_speed_rc_osc;
		logic middle_speed_rc_osc;
		logic low_speed_rc_osc;
		logic slow_crystal_osc;
	} scs_osc_s;

	// Oscillator enables leaving the block.
	typedef struct packed {
		logic fast_crystal_osc;
		logic high_speed_rc_osc;
		logic middle_speed_rc_osc;
		logic low_speed_rc_osc;
		logic slow_crystal_osc;
		logic lxt_speedup;
	} scs_osc_en_s;

endpackage : scs_pkg

// ### rtl/scs_sync3.sv
`timescale 1ns/1ps
module scs_sync3 #(
	parameter int W = 5
) (
	// Clock and reset.
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// Asynchronous levels in, filtered levels out.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	////////////////////////////////////////////////////////////////////////////
	// One three-stage chain per bit; the output moves only once stages two and
	// three agree, so a single metastable sample never reaches the block.
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic s1_q, s2_q, s3_q, out_q, out_d;

			// Next value of the filtered level.
			always_comb begin
				out_d = (s2_q == s3_q) ? s3_q : out_q;
			end

			// Registers of the chain.
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					s3_q  <= 1'b0;
					out_q <= 1'b0;
				end else begin
					s1_q  <= d[gi];
					s2_q  <= s1_q;
					s3_q  <= s2_q;
					out_q <= out_d;
				end
			end

			assign q[gi] = out_q;
		end
	endgenerate

endmodule : scs_sync3

// ### tb/scs_osc_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behavioural oscillators; a stopped oscillator rests low, as a real one does.
module scs_osc_model (
	// Enables and pin routing from the block.
	input  wire scs_pkg::scs_osc_en_s osc_en,
	input  wire logic                 xt_pin_osc,
	// Oscillator levels to the block.
	output scs_pkg::scs_osc_s         osc
);
	logic fast_crystal_osc  = 1'b0;
	logic high_speed_rc_osc = 1'b0;
	logic middle_speed_rc_osc = 1'b0;
	logic low_speed_rc_osc = 1'b0;
	logic slow_crystal_osc  = 1'b0;

	// Pack the levels in the order the package declares.
	assign osc = {fast_crystal_osc, high_speed_rc_osc, middle_speed_rc_osc, low_speed_rc_osc, slow_crystal_osc};

	// Each RC and the fast crystal toggles only while enabled.
	always #40 fast_crystal_osc = osc_en.fast_crystal_osc & ~fast_crystal_osc;
	always #30 high_speed_rc_osc = osc_en.high_speed_rc_osc & ~high_speed_rc_osc;
	always #70 middle_speed_rc_osc = osc_en.middle_speed_rc_osc & ~middle_speed_rc_osc;
	always #110 low_speed_rc_osc = osc_en.low_speed_rc_osc & ~low_speed_rc_osc;

	// The crystal needs its pins and a start time; low power starts slower but runs alike.
	always begin
		wait (osc_en.slow_crystal_osc && xt_pin_osc);
		#(osc_en.lxt_speedup ? 150 : 300);
		while (osc_en.slow_crystal_osc && xt_pin_osc) begin
			#90 slow_crystal_osc = ~slow_crystal_osc;
		end
		slow_crystal_osc = 1'b0;
	end
endmodule : scs_osc_model

// ### tb/tb_system_clock_source_select.sv
`timescale 1ns/1ps
module tb_system_clock_source_select;
	logic                 clk_sys = 1'b0;
	logic                 rst     = 1'b1;
	logic                 wr      = 1'b0;
	logic                 rd      = 1'b0;
	logic                 halt    = 1'b0;
	logic [1:0]           addr    = 2'h0;
	logic [7:0]           wdata   = 8'h00;
	logic [7:0]           rdata, rv, wv, sv, hv;
	logic [4:0]           cur, prv;
	logic                 sel_en, xt_pin_osc, sys_clk, hs_clk, sub_clk;
	logic [2:0]           rc_freq_code;
	scs_pkg::scs_osc_s    osc;
	scs_pkg::scs_osc_en_s osc_en;
	int                   err_total = 0;
	int                   checks_done = 0;
	int                   seed = 51;
	int                   cycles = 0;
	int                   n;
	int                   cnt [5] = '{default: 0};
	int                   snap [5];
	int                   dlt [5];

	// A 200 MHz clock.
	initial forever #2.5 clk_sys = ~clk_sys;

	// Small start-up limits keep the run short: 20 cycles fast, 40 low power.
	scs_clock_select #(.SU_FAST_CYC(20'h14), .SU_SLOW_CYC(20'h28)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .halt(halt), .osc(osc),
		.osc_en(osc_en), .rc_freq_code(rc_freq_code), .xt_pin_osc(xt_pin_osc), .sys_clk(sys_clk),
		.hs_clk(hs_clk), .sub_clk(sub_clk));
	scs_osc_model osc_u (.osc_en(osc_en), .xt_pin_osc(xt_pin_osc), .osc(osc));

	////////////////////////////////////////////////////////////////////////////////
	// Count rising edges of the three output clocks, the fast RC and the crystal by sampling; a hang is cut short here.
	assign cur = {osc.slow_crystal_osc, osc.high_speed_rc_osc, sub_clk, hs_clk, sys_clk};
	always @(posedge clk_sys) begin
		prv <= cur;
		cycles <= cycles + 1;
		for (int i = 0; i < 5; i++) begin
			if (cur[i] === 1'b1 && prv[i] === 1'b0) cnt[i] <= cnt[i] + 1;
		end
		if (cycles == 60000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("unexpected at %0t: count %h, expected %h to %h", $time, got, lo, hi);
		end
	endtask : chk_rng

	// A gap cycle after each strobe so no strobe is assigned twice in one step.
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		@(posedge clk_sys);
	endtask : reg_wr

	task automatic reg_rd(input logic [1:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 rv = rdata;
		@(posedge clk_sys);
	endtask : reg_rd

	task automatic measure(input int len);
		snap = cnt;
		repeat (len) @(posedge clk_sys);
		foreach (dlt[i]) dlt[i] = cnt[i] - snap[i];
	endtask : measure

	// Polls the crystal ready bit, two cycles a read.
	task automatic wait_rdy();
		n = 0;
		do begin
			reg_rd(scs_pkg::ADDR_LXTC);
			n += 2;
		end while (rv[1] !== 1'b1 && n < 200);
	endtask : wait_rdy

	function automatic int exp_div(input logic [2:0] c);
		return (c == scs_pkg::CKS_UNDIV) ? 1 : 64 >> c;
	endfunction : exp_div

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		reg_rd(scs_pkg::ADDR_SCC);
		chk(rv, 8'he0);
		reg_rd(scs_pkg::ADDR_INTERNAL_RC_CONTROL);
		chk(rv & 8'hfd, 8'h11);
		reg_rd(scs_pkg::ADDR_HXTC);
		chk(rv, 8'h00);
		reg_rd(scs_pkg::ADDR_LXTC);
		chk(rv, 8'h04);
		chk({2'h0, osc_en}, 8'h15);
		$display("test reset done");
		// Random selections; the chosen fast source must run unless parked with its enable low.
		repeat (12) begin
			wv = $random(seed) & 8'h1d;
			sv = $random(seed) & 8'hef;
			hv = $random(seed) & 8'h01;
			reg_wr(scs_pkg::ADDR_INTERNAL_RC_CONTROL, wv);
			reg_wr(scs_pkg::ADDR_HXTC, hv);
			reg_wr(scs_pkg::ADDR_SCC, sv);
			reg_rd(scs_pkg::ADDR_INTERNAL_RC_CONTROL);
			chk(rv & 8'h1d, wv);
			chk({5'h0, rc_freq_code}, {5'h0, wv[4:2]});
			reg_rd(scs_pkg::ADDR_HXTC);
			chk(rv, hv);
			reg_rd(scs_pkg::ADDR_SCC);
			chk(rv, sv);
			sel_en = sv[3] ? osc_en.fast_crystal_osc : (wv[4:2] >= scs_pkg::IRC_FIRST_HIGH_SPEED_RC_OSC ? osc_en.high_speed_rc_osc : osc_en.middle_speed_rc_osc);
			chk({6'h0, sel_en, osc_en.low_speed_rc_osc}, {6'h0, sv[7:5] != 3'h7 || (sv[3] ? hv[0] : wv[0]), 1'b1});
		end
		$display("test source select done");
		// Divider ratios against the fast RC.
		reg_wr(scs_pkg::ADDR_INTERNAL_RC_CONTROL, 8'h11);
		for (int k = 0; k < 7; k++) begin
			reg_wr(scs_pkg::ADDR_SCC, {k[2:0], 5'h00});
			measure(40);
			measure(4000);
			chk_rng(dlt[0], dlt[3] / exp_div(k[2:0]) - 2, dlt[3] / exp_div(k[2:0]) + 2);
			chk_rng(dlt[1], dlt[3] - 2, dlt[3] + 2);
		end
		$display("test divider done");
		// Halt stops the system clock; the fast clock stays by its idle enable.
		reg_wr(scs_pkg::ADDR_SCC, 8'hc2);
		halt <= 1'b1;
		measure(40);
		measure(400);
		chk_rng(dlt[0], 0, 0);
		chk_rng(dlt[1], dlt[3] - 2, dlt[3] + 2);
		chk_rng(dlt[2], 0, 0);
		halt <= 1'b0;
		$display("test halt done");
		// Crystal in speed-up, then as subclock with its mode locked.
		reg_wr(scs_pkg::ADDR_LXTC, 8'h0d);
		chk({6'h0, xt_pin_osc, osc_en.slow_crystal_osc}, 8'h03);
		wait_rdy();
		chk_rng(n, 15, 25);
		reg_wr(scs_pkg::ADDR_SCC, 8'he4);
		chk({7'h0, osc_en.low_speed_rc_osc}, 8'h00);
		measure(40);
		measure(2000);
		chk_rng(dlt[0], dlt[4] - 2, dlt[4] + 2);
		reg_wr(scs_pkg::ADDR_LXTC, 8'h09);
		reg_rd(scs_pkg::ADDR_LXTC);
		chk(rv, 8'h0f);
		// Off the subclock the mode may drop to low power and the crystal keeps running.
		reg_wr(scs_pkg::ADDR_SCC, 8'hc0);
		reg_wr(scs_pkg::ADDR_LXTC, 8'h09);
		reg_rd(scs_pkg::ADDR_LXTC);
		chk(rv, 8'h0b);
		measure(2000);
		chk_rng(dlt[4], 50, 60);
		reg_wr(scs_pkg::ADDR_LXTC, 8'h08);
		reg_rd(scs_pkg::ADDR_LXTC);
		chk(rv, 8'h08);
		reg_wr(scs_pkg::ADDR_LXTC, 8'h09);
		wait_rdy();
		chk_rng(n, 35, 45);
		reg_wr(scs_pkg::ADDR_LXTC, 8'h00);
		chk({7'h0, xt_pin_osc}, 8'h00);
		#1 chk(rdata, 8'h00);
		$display("test crystal done");
		end_of_test();
	end
endmodule : tb_system_clock_source_select
